//--- src/tmr_pkg.sv
package tmr_pkg;
    localparam logic [7:0]  ADDR_CTRL   = 8'hFB;
    localparam logic [7:0]  ADDR_MODE   = 8'hF5;
    localparam logic [7:0]  ADDR_DATA_H = 8'hF8;
    localparam logic [7:0]  ADDR_DATA_L = 8'hF9;
    localparam logic [7:0]  ADDR_CNT_H  = 8'hFC;
    localparam logic [7:0]  ADDR_CNT_L  = 8'hFD;
    localparam logic [7:0]  ADDR_PCL    = 8'hE5;
    localparam logic [7:0]  CTRL_RST    = 8'h00;
    localparam logic [7:0]  MODE_RST    = 8'h00;
    localparam logic [7:0]  PCL_RST     = 8'h00;
    localparam logic [15:0] DATA_RST    = 16'h0000;
    localparam logic [15:0] CNT_RST     = 16'h0000;
    localparam logic [15:0] CNT_MAX     = 16'hFFFF;
    localparam logic [7:0]  CTRL_WMASK  = 8'hE6;
    localparam int          CLR_BIT     = 3;
    localparam int          OVIE_BIT    = 2;
    localparam int          MIE_BIT     = 1;
    localparam int          MPND_BIT    = 0;
    localparam int          OPND_BIT    = 2;
    localparam int          PRE_W       = 10;
    localparam logic [2:0]  CLK_D1024   = 3'h0;
    localparam logic [2:0]  CLK_D256    = 3'h1;
    localparam logic [2:0]  CLK_D64     = 3'h2;
    localparam logic [2:0]  CLK_D8      = 3'h3;
    localparam logic [2:0]  CLK_D1      = 3'h4;
    localparam logic [2:0]  CLK_EXT_FALL = 3'h5;
    localparam logic [2:0]  CLK_EXT_RISE = 3'h6;
    localparam logic [2:0]  CLK_STOP    = 3'h7;
    localparam logic [1:0]  PCL_CAPTURE = 2'h0;
    localparam logic [1:0]  PCL_OUTPUT  = 2'h3;
    localparam logic [7:0]  VEC_OVF     = 8'hEA;
    localparam logic [7:0]  VEC_MATCH   = 8'hE8;
    localparam logic [7:0]  VEC_NONE    = 8'h00;
    typedef enum logic [1:0] {
        TMR_INTERVAL = 2'b00,
        TMR_CAP_FALL = 2'b01,
        TMR_CAP_RISE = 2'b10,
        TMR_PWM      = 2'b11
    } tmr_mode_t;
endpackage : tmr_pkg

//--- src/tmr_top.sv
module tmr_top (
    input  wire logic       mclk,               // System clock, 100 MHz.
    input  wire logic       arst_n,             // Asynchronous reset, active low.
    input  wire logic [7:0] reg_addr,           // Register address.
    input  wire logic       reg_wr,             // Register write strobe.
    input  wire logic       reg_rd,             // Register read strobe.
    input  wire logic [7:0] reg_wdata,          // Register write data.
    output logic      [7:0] reg_rdata,          // Register read data, one cycle after reg_rd.
    input  wire logic       ovf_ack,            // CPU serviced overflow interrupt.
    input  wire logic       match_ack,          // CPU serviced match/capture interrupt.
    output logic            overflow_interrupt, // Overflow request.
    output logic            match_capture_interrupt, // Match/capture request.
    output logic            interrupt_level_three,   // Either request.
    output logic      [7:0] irq_vector,         // Vector of the request in front.
    input  wire logic       capture_input_pin,  // Capture pin level.
    input  wire logic       external_clock_pin, // External counter clock.
    output logic            toggle_output_pin,  // Interval toggle output.
    output logic            pulse_output_pin,   // PWM output.
    output logic            capture_pin_oe_n    // Capture pin driven as output, active low.
);
    localparam int PRE_W_L = tmr_pkg::PRE_W;

    logic        rst_meta_ff;
    logic        rst_n;
    logic [1:0]  ext_sync_ff;
    logic        ext_prev_ff;
    logic [1:0]  cap_sync_ff;
    logic        cap_prev_ff;
    logic [PRE_W_L-1:0] pre_ff;
    logic [PRE_W_L-1:0] nxt_pre;
    logic [15:0] cnt_ff;
    logic [15:0] nxt_cnt;
    logic [15:0] data_ff;
    logic [15:0] nxt_data;
    logic [7:0]  ctrl_ff;
    logic [7:0]  nxt_ctrl;
    logic [7:0]  mode_ff;
    logic [7:0]  nxt_mode;
    logic [7:0]  pcl_ff;
    logic [7:0]  nxt_pcl;
    logic        mpnd_ff;
    logic        nxt_mpnd;
    logic        opnd_ff;
    logic        nxt_opnd;
    logic        tog_ff;
    logic        nxt_tog;
    logic        pwm_ff;
    logic        nxt_pwm;
    logic [7:0]  rdata_ff;
    logic [7:0]  nxt_rdata;
    logic [7:0]  vec_ff;
    logic [7:0]  nxt_vec;
    logic        tick;
    logic        ext_rise;
    logic        ext_fall;
    logic        cap_edge;
    logic        clr_wr;
    logic        match_ev;
    logic        ovf_ev;
    logic        cap_ev;
    logic        ovf_irq;
    logic        mat_irq;
    logic [2:0]  clk_sel;
    tmr_pkg::tmr_mode_t mode;

    // Reset release goes through two flops so every flop leaves reset on the same edge.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_ff <= 1'b0;
            rst_n       <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n       <= rst_meta_ff;
        end
    end

    // Pin synchronisers; the third flop gives the edge reference.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ext_sync_ff <= 2'h0;
            ext_prev_ff <= 1'b0;
            cap_sync_ff <= 2'h0;
            cap_prev_ff <= 1'b0;
        end else begin
            ext_sync_ff <= {ext_sync_ff[0], external_clock_pin};
            ext_prev_ff <= ext_sync_ff[1];
            cap_sync_ff <= {cap_sync_ff[0], capture_input_pin};
            cap_prev_ff <= cap_sync_ff[1];
        end
    end

    assign ext_rise = ext_sync_ff[1] & ~ext_prev_ff;
    assign ext_fall = ~ext_sync_ff[1] & ext_prev_ff;
    assign clk_sel  = ctrl_ff[7:5];
    assign mode     = tmr_pkg::tmr_mode_t'(mode_ff[1:0]);
    assign clr_wr   = reg_wr && (reg_addr == tmr_pkg::ADDR_CTRL) && reg_wdata[tmr_pkg::CLR_BIT];
    assign nxt_pre  = pre_ff + PRE_W_L'(1);

    // Capture needs the pin routed as capture input.
    always_comb begin
        cap_edge = 1'b0;
        if (pcl_ff[1:0] == tmr_pkg::PCL_CAPTURE) begin
            if (mode == tmr_pkg::TMR_CAP_RISE) begin
                cap_edge = cap_sync_ff[1] & ~cap_prev_ff;
            end else if (mode == tmr_pkg::TMR_CAP_FALL) begin
                cap_edge = ~cap_sync_ff[1] & cap_prev_ff;
            end
        end
    end

    always_comb begin
        case (clk_sel)
            tmr_pkg::CLK_D1024:    tick = &pre_ff[9:0];
            tmr_pkg::CLK_D256:     tick = &pre_ff[7:0];
            tmr_pkg::CLK_D64:      tick = &pre_ff[5:0];
            tmr_pkg::CLK_D8:       tick = &pre_ff[2:0];
            tmr_pkg::CLK_D1:       tick = 1'b1;
            tmr_pkg::CLK_EXT_FALL: tick = ext_fall;
            tmr_pkg::CLK_EXT_RISE: tick = ext_rise;
            tmr_pkg::CLK_STOP:     tick = 1'b0;
            default:               tick = 1'b0;
        endcase
    end

    always_comb begin
        nxt_cnt   = cnt_ff;
        nxt_data  = data_ff;
        nxt_ctrl  = ctrl_ff;
        nxt_mode  = mode_ff;
        nxt_pcl   = pcl_ff;
        nxt_mpnd  = mpnd_ff;
        nxt_opnd  = opnd_ff;
        nxt_tog   = tog_ff;
        nxt_rdata = rdata_ff;
        match_ev  = 1'b0;
        ovf_ev    = 1'b0;
        cap_ev    = 1'b0;
        if (reg_wr) begin
            case (reg_addr)
                tmr_pkg::ADDR_CTRL: begin
                    nxt_ctrl = reg_wdata & tmr_pkg::CTRL_WMASK;
                    if (!reg_wdata[tmr_pkg::MPND_BIT]) begin
                        nxt_mpnd = 1'b0;
                    end
                    if (reg_wdata[tmr_pkg::CLR_BIT]) begin
                        nxt_cnt = tmr_pkg::CNT_RST;
                    end
                end
                tmr_pkg::ADDR_MODE: begin
                    nxt_mode = {5'h00, 1'b0, reg_wdata[1:0]};
                    if (!reg_wdata[tmr_pkg::OPND_BIT]) begin
                        nxt_opnd = 1'b0;
                    end
                end
                tmr_pkg::ADDR_DATA_H: nxt_data[15:8] = reg_wdata;
                tmr_pkg::ADDR_DATA_L: nxt_data[7:0] = reg_wdata;
                tmr_pkg::ADDR_PCL:    nxt_pcl = reg_wdata;
                default: begin
                end
            endcase
        end
        if (ovf_ack) begin
            nxt_opnd = 1'b0;
        end
        if (match_ack) begin
            nxt_mpnd = 1'b0;
        end
        // A clear written in the same cycle wins over the tick.
        if (tick && !clr_wr) begin
            if (mode == tmr_pkg::TMR_INTERVAL && cnt_ff == data_ff) begin
                match_ev = 1'b1;
                nxt_cnt  = tmr_pkg::CNT_RST;
                nxt_tog  = ~tog_ff;
            end else begin
                nxt_cnt = cnt_ff + 16'h0001;
                ovf_ev  = (cnt_ff == tmr_pkg::CNT_MAX);
                if (mode == tmr_pkg::TMR_PWM && cnt_ff == data_ff) begin
                    match_ev = 1'b1;
                end
            end
        end
        // A capture edge beats a CPU write of the reference in the same cycle.
        if (cap_edge) begin
            cap_ev   = 1'b1;
            nxt_data = cnt_ff;
        end
        // Hardware events are applied last so a set beats any clear.
        if (match_ev || cap_ev) begin
            nxt_mpnd = 1'b1;
        end
        if (ovf_ev) begin
            nxt_opnd = 1'b1;
        end
        if (reg_rd) begin
            case (reg_addr)
                tmr_pkg::ADDR_CTRL:   nxt_rdata = ctrl_ff | {7'h00, mpnd_ff};
                tmr_pkg::ADDR_MODE:   nxt_rdata = {5'h00, opnd_ff, mode_ff[1:0]};
                tmr_pkg::ADDR_DATA_H: nxt_rdata = data_ff[15:8];
                tmr_pkg::ADDR_DATA_L: nxt_rdata = data_ff[7:0];
                tmr_pkg::ADDR_CNT_H:  nxt_rdata = cnt_ff[15:8];
                tmr_pkg::ADDR_CNT_L:  nxt_rdata = cnt_ff[7:0];
                tmr_pkg::ADDR_PCL:    nxt_rdata = pcl_ff;
                default:              nxt_rdata = 8'h00;
            endcase
        end
    end

    // The PWM pin is registered, so it follows the compare one cycle late.
    assign nxt_pwm = (mode == tmr_pkg::TMR_PWM) && (data_ff > cnt_ff);
    assign ovf_irq = opnd_ff & ctrl_ff[tmr_pkg::OVIE_BIT];
    assign mat_irq = mpnd_ff & ctrl_ff[tmr_pkg::MIE_BIT];

    always_comb begin
        if (mat_irq) begin
            nxt_vec = tmr_pkg::VEC_MATCH;
        end else if (ovf_irq) begin
            nxt_vec = tmr_pkg::VEC_OVF;
        end else begin
            nxt_vec = tmr_pkg::VEC_NONE;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pre_ff   <= '0;
            cnt_ff   <= tmr_pkg::CNT_RST;
            data_ff  <= tmr_pkg::DATA_RST;
            ctrl_ff  <= tmr_pkg::CTRL_RST;
            mode_ff  <= tmr_pkg::MODE_RST;
            pcl_ff   <= tmr_pkg::PCL_RST;
            mpnd_ff  <= 1'b0;
            opnd_ff  <= 1'b0;
            tog_ff   <= 1'b0;
            pwm_ff   <= 1'b0;
            rdata_ff <= 8'h00;
            vec_ff   <= tmr_pkg::VEC_NONE;
        end else begin
            pre_ff   <= nxt_pre;
            cnt_ff   <= nxt_cnt;
            data_ff  <= nxt_data;
            ctrl_ff  <= nxt_ctrl;
            mode_ff  <= nxt_mode;
            pcl_ff   <= nxt_pcl;
            mpnd_ff  <= nxt_mpnd;
            opnd_ff  <= nxt_opnd;
            tog_ff   <= nxt_tog;
            pwm_ff   <= nxt_pwm;
            rdata_ff <= nxt_rdata;
            vec_ff   <= nxt_vec;
        end
    end

    assign reg_rdata               = rdata_ff;
    assign overflow_interrupt      = ovf_irq;
    assign match_capture_interrupt = mat_irq;
    assign interrupt_level_three   = ovf_irq | mat_irq;
    assign irq_vector              = vec_ff;
    assign toggle_output_pin       = tog_ff;
    assign pulse_output_pin        = pwm_ff;
    assign capture_pin_oe_n        = ~(pcl_ff[1:0] == tmr_pkg::PCL_OUTPUT);

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    sequence interval_hit_s;
        tick && !clr_wr && mode == tmr_pkg::TMR_INTERVAL && cnt_ff == data_ff;
    endsequence
    sequence interval_done_s;
        cnt_ff == 16'h0000 && tog_ff != $past(tog_ff) && mpnd_ff;
    endsequence

    interval_match_a: assert property (interval_hit_s |=> interval_done_s)
        else $error("interval match did not clear, toggle and flag");
    pwm_no_clear_a: assert property (tick && !clr_wr && mode == tmr_pkg::TMR_PWM &&
        cnt_ff == data_ff && !cap_edge |=> cnt_ff == $past(cnt_ff) + 16'h0001 && mpnd_ff)
        else $error("pwm match cleared counter or missed flag");
    wrap_ovf_a: assert property (tick && !clr_wr && mode != tmr_pkg::TMR_INTERVAL &&
        cnt_ff == 16'hFFFF |=> cnt_ff == 16'h0000 && opnd_ff)
        else $error("wrap did not set overflow pending");
    pwm_level_a: assert property (mode == tmr_pkg::TMR_PWM && !reg_wr ##1
        mode == tmr_pkg::TMR_PWM |=> pulse_output_pin == ($past(data_ff) > $past(cnt_ff)))
        else $error("pwm level wrong");
    capture_load_a: assert property (cap_edge |=> data_ff == $past(cnt_ff) && mpnd_ff)
        else $error("capture did not load counter");
    stop_hold_a: assert property ((clk_sel == tmr_pkg::CLK_STOP && !reg_wr) [*2]
        |-> cnt_ff == $past(cnt_ff))
        else $error("counter moved while stopped");
    clear_write_a: assert property (clr_wr |=> cnt_ff == 16'h0000)
        else $error("counter clear write ignored");
    pend_write_a: assert property (reg_wr && reg_addr == tmr_pkg::ADDR_CTRL &&
        !reg_wdata[0] && !match_ev && !cap_edge |=> !mpnd_ff)
        else $error("pending not cleared by write");
    ack_clear_a: assert property (ovf_ack && !ovf_ev |=> !opnd_ff)
        else $error("overflow pending not cleared on service");
    step_one_a: assert property (tick && !clr_wr && mode == tmr_pkg::TMR_CAP_RISE
        |=> cnt_ff == $past(cnt_ff) + 16'h0001)
        else $error("counter did not step by one");
    vector_a: assert property (mat_irq |=> irq_vector == 8'hE8 || !$past(mat_irq))
        else $error("match vector wrong");
    reset_ctrl_a: assert property ($rose(rst_n) |-> ctrl_ff == 8'h00 && mode_ff == 8'h00)
        else $error("control not zero after reset");
endmodule : tmr_top

//--- tb/tmr_pin_model.sv
module tmr_pin_model (
    input  wire logic mclk,    // System clock.
    output logic      ext_clk, // External counter clock, still between bursts.
    output logic      cap_pin  // Capture input level, idles low.
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        ext_clk = 1'b0;
        cap_pin = 1'b0;
    end
    // Every level is held four cycles so the two-flop synchroniser cannot miss an edge.
    task automatic ext_pulses(input int n);
        repeat (n) begin
            repeat (4) @(posedge mclk);
            #1 ext_clk = 1'b1;
            repeat (4) @(posedge mclk);
            #1 ext_clk = 1'b0;
        end
    endtask : ext_pulses
    task automatic cap_pulse();
        @(posedge mclk);
        #1 cap_pin = 1'b1;
        repeat (4) @(posedge mclk);
        #1 cap_pin = 1'b0;
    endtask : cap_pulse
endmodule : tmr_pin_model

//--- tb/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic       mclk, arst_n, reg_wr, reg_rd, ovf_ack, match_ack, ovf_irq, mc_irq, lvl3, cap, ext;
    logic       tog, pwm, oe_n;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, irq_vector, b;
    logic [15:0] c, c2;
    int         n_mismatch, checks, d, n;
    tmr_top tmr_top_inst (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ovf_ack(ovf_ack),
        .match_ack(match_ack), .overflow_interrupt(ovf_irq), .match_capture_interrupt(mc_irq),
        .interrupt_level_three(lvl3), .irq_vector(irq_vector), .capture_input_pin(cap),
        .external_clock_pin(ext), .toggle_output_pin(tog), .pulse_output_pin(pwm),
        .capture_pin_oe_n(oe_n));
    tmr_pin_model tmr_pin_model_inst (.mclk(mclk), .ext_clk(ext), .cap_pin(cap));
    always #5 mclk = ~mclk;
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            n_mismatch++;
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        #1 {reg_wr, reg_addr, reg_wdata} = {1'b1, a, v};
        @(posedge mclk);
        #1 reg_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge mclk);
        #1 {reg_rd, reg_addr} = {1'b1, a};
        @(posedge mclk);
        #1 reg_rd = 1'b0;
        v = reg_rdata;
    endtask : rd
    task automatic rd16(input logic [7:0] a, output logic [15:0] v);
        rd(a, v[15:8]);
        rd(a + 8'h01, v[7:0]);
    endtask : rd16
    // Counts the cycles until the signal changes; a run that reaches the limit is a hang.
    task automatic wait_change(ref logic s, input int lim, output int cnt);
        logic s0;
        s0 = s;
        cnt = 0;
        while (s === s0 && cnt < lim) begin
            @(posedge mclk);
            #1 cnt++;
        end
        chk("wait limit", 1'b1, cnt < lim);
    endtask : wait_change
    task automatic ack(input logic ov);
        @(posedge mclk);
        #1 {ovf_ack, match_ack} = {ov, !ov};
        @(posedge mclk);
        #1 {ovf_ack, match_ack} = 2'b00;
    endtask : ack
    function automatic logic [15:0] exp_ticks(input int t, input int sel);
        int sh[5] = '{10, 8, 6, 3, 0};
        return 16'(t >> sh[sel]);
    endfunction : exp_ticks
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : wrap_up
    initial begin
        #950000;
        n_mismatch++;
        wrap_up();
    end
    initial begin
        {mclk, arst_n, reg_wr, reg_rd, ovf_ack, match_ack, reg_addr, reg_wdata} = '0;
        n_mismatch = 0;
        checks = 0;
        void'($urandom(32'h605dd83b));
        repeat (16) @(posedge mclk);
        #1 arst_n = 1'b1;
        repeat (3) @(posedge mclk);
        rd(tmr_pkg::ADDR_CTRL, b);
        chk("ctrl reset", tmr_pkg::CTRL_RST, b);
        rd(tmr_pkg::ADDR_MODE, b);
        chk("mode reset", tmr_pkg::MODE_RST, b);
        rd(8'h10, b);
        chk("unmapped read", 8'h00, b);
        chk("irq reset", 1'b0, lvl3);
        chk("pin oe reset", 1'b1, oe_n);
        $display("test reset done");
        wr(tmr_pkg::ADDR_DATA_H, 8'hFF);
        wr(tmr_pkg::ADDR_DATA_L, 8'hFF);
        for (int s = 0; s < 5; s++) begin
            wr(tmr_pkg::ADDR_CTRL, 8'hE8);
            wr(tmr_pkg::ADDR_CTRL, {3'(s), 5'h00});
            repeat (2046) @(posedge mclk);
            wr(tmr_pkg::ADDR_CTRL, 8'hE0);
            rd16(tmr_pkg::ADDR_CNT_H, c);
            chk("prescaled count", exp_ticks(2048, s), c);
        end
        repeat (40) @(posedge mclk);
        rd16(tmr_pkg::ADDR_CNT_H, c2);
        chk("stopped count", c, c2);
        wr(tmr_pkg::ADDR_CTRL, 8'hE8);
        rd16(tmr_pkg::ADDR_CNT_H, c);
        chk("cleared count", 16'h0000, c);
        $display("test prescaler done");
        d = $urandom_range(12, 3);
        wr(tmr_pkg::ADDR_DATA_H, 8'h00);
        wr(tmr_pkg::ADDR_DATA_L, 8'(d));
        wr(tmr_pkg::ADDR_CTRL, 8'h8A);
        wait_change(tog, 300, n);
        wait_change(tog, 300, n);
        chk("toggle period", 16'(d + 1), 16'(n));
        @(posedge mclk);
        #1 chk("match vector", tmr_pkg::VEC_MATCH, irq_vector);
        // Stop the counter first so no fresh match can land on the service edge.
        wr(tmr_pkg::ADDR_CTRL, 8'hE3);
        ack(1'b0);
        chk("match irq after ack", 1'b0, mc_irq);
        wr(tmr_pkg::ADDR_CTRL, 8'h88);
        repeat (20) @(posedge mclk);
        #1 chk("masked match irq", 1'b0, mc_irq);
        wr(tmr_pkg::ADDR_CTRL, 8'hE1);
        rd(tmr_pkg::ADDR_CTRL, b);
        chk("pending polled", 8'hE1, b);
        wr(tmr_pkg::ADDR_CTRL, 8'hE0);
        rd(tmr_pkg::ADDR_CTRL, b);
        chk("pending cleared", 8'hE0, b);
        $display("test interval done");
        d = $urandom_range(255, 16);
        wr(tmr_pkg::ADDR_DATA_L, 8'(d));
        wr(tmr_pkg::ADDR_MODE, 8'h03);
        wr(tmr_pkg::ADDR_CTRL, 8'hE8);
        wr(tmr_pkg::ADDR_CTRL, 8'h84);
        wait_change(ovf_irq, 70000, n);
        wait_change(pwm, 300, n);
        wait_change(pwm, 300, n);
        chk("pwm high run", 16'(d), 16'(n));
        chk("overflow vector", tmr_pkg::VEC_OVF, irq_vector);
        rd(tmr_pkg::ADDR_MODE, b);
        chk("overflow pending", 8'h07, b);
        rd(tmr_pkg::ADDR_CTRL, b);
        chk("pwm match pending", 8'h85, b);
        ack(1'b1);
        chk("ovf irq after ack", 1'b0, ovf_irq);
        $display("test pwm done");
        wr(tmr_pkg::ADDR_PCL, 8'h00);
        for (int m = 1; m < 3; m++) begin
            wr(tmr_pkg::ADDR_MODE, 8'(m));
            wr(tmr_pkg::ADDR_CTRL, 8'hCA);
            d = $urandom_range(20, 1);
            tmr_pin_model_inst.ext_pulses(d);
            repeat (5) @(posedge mclk);
            tmr_pin_model_inst.cap_pulse();
            // A rising-edge capture already fires inside the pulse, so look at the level, not a change.
            repeat (5) @(posedge mclk);
            #1 chk("capture irq", 1'b1, mc_irq);
            rd16(tmr_pkg::ADDR_DATA_H, c);
            chk("captured count", 16'(d), c);
            ack(1'b0);
        end
        wr(tmr_pkg::ADDR_PCL, 8'h03);
        chk("pin as output", 1'b0, oe_n);
        tmr_pin_model_inst.cap_pulse();
        repeat (10) @(posedge mclk);
        #1 chk("capture off as output", 1'b0, mc_irq);
        $display("test capture done");
        wrap_up();
    end
endmodule : tb_top
